/* File: hw/ptc_cfg.svh */
/*
 * Offsets, field positions, reset values and prescaler tap masks
 * for the prescaled 8-bit timer/counter.
 * Assumes an 8-bit register address and 8-bit register data.
 */
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

`define PTC_ADDR_W          8
`define PTC_DATA_W          8
`define PTC_ADDR_COUNT      8'h32
`define PTC_ADDR_CONTROL    8'h33
`define PTC_ADDR_FLAG       8'h38
`define PTC_ADDR_MASK       8'h39

`define PTC_CS_LSB          0
`define PTC_CS_MSB          2
`define PTC_OVF_BIT         0

`define PTC_CONTROL_RST     3'h0
`define PTC_COUNT_RST       8'h00
`define PTC_FLAG_RST        1'b0
`define PTC_MASK_RST        1'b0
`define PTC_PRESC_RST       10'h000

`define PTC_PRESC_W         10
`define PTC_TAP_DIV8        10'h007
`define PTC_TAP_DIV64       10'h03F
`define PTC_TAP_DIV256      10'h0FF
`define PTC_TAP_DIV1024     10'h3FF
`define PTC_COUNT_MAX       8'hFF
`define PTC_COUNT_STEP      8'h01

`endif

/* File: hw/ptc_pkg.sv */
/*
 * Types of the prescaled 8-bit timer/counter.
 * Assumes ptc_cfg.svh for widths.
 */
`include "ptc_cfg.svh"

package ptc_pkg;

	typedef enum logic [2:0] {
		ptc_cs_stop     = 3'h0,
		ptc_cs_clk      = 3'h1,
		ptc_cs_div8     = 3'h2,
		ptc_cs_div64    = 3'h3,
		ptc_cs_div256   = 3'h4,
		ptc_cs_div1024  = 3'h5,
		ptc_cs_ext_fall = 3'h6,
		ptc_cs_ext_rise = 3'h7
	} ptc_clk_sel_t;

	typedef struct packed {
		logic [`PTC_PRESC_W-1:0] count;
	} ptc_presc_state_t;

	typedef struct packed {
		logic sync_first;
		logic sync_second;
		logic level_prev;
	} ptc_edge_state_t;

	typedef struct packed {
		ptc_clk_sel_t            clk_sel;
		logic [`PTC_DATA_W-1:0]  count;
		logic                    ovf_flag;
		logic                    ovf_mask;
		logic [`PTC_DATA_W-1:0]  rdata;
	} ptc_core_state_t;

endpackage

/* File: hw/ptc_tick_if.sv */
/*
 * Count-tick carrier between prescaler, pin edge detector and core.
 * Assumes all parties run on the one CPU clock.
 */
`timescale 1ns/100ps

interface ptc_tick_if;
	logic [3:0] div_tick;
	logic       ext_rise;
	logic       ext_fall;

	modport prescaler (output div_tick);
	modport edge_src  (output ext_rise, output ext_fall);
	modport core      (input div_tick, input ext_rise, input ext_fall);
endinterface

/* File: hw/ptc_prescaler.sv */
/*
 * Free-running 10-bit prescaler with /8, /64, /256, /1024 taps.
 * Assumes clk_in is the oscillator clock itself.
 */
`timescale 1ns/100ps
`include "ptc_cfg.svh"

module ptc_prescaler (
	input wire logic          clk_in,
	input wire logic          rst_in,
	ptc_tick_if.prescaler     tick
);
	ptc_pkg::ptc_presc_state_t state_reg;
	ptc_pkg::ptc_presc_state_t state_next;

	// Never cleared by software, so taps stay shareable
	always_comb begin
		state_next       = state_reg;
		state_next.count = state_reg.count + `PTC_PRESC_W'(1);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg.count <= `PTC_PRESC_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// One-cycle pulse once per period, taken straight off the oscillator count
	assign tick.div_tick[0] = ((state_reg.count & `PTC_TAP_DIV8) == `PTC_TAP_DIV8);
	assign tick.div_tick[1] = ((state_reg.count & `PTC_TAP_DIV64) == `PTC_TAP_DIV64);
	assign tick.div_tick[2] = ((state_reg.count & `PTC_TAP_DIV256) == `PTC_TAP_DIV256);
	assign tick.div_tick[3] = ((state_reg.count & `PTC_TAP_DIV1024) == `PTC_TAP_DIV1024);
endmodule

/* File: hw/ptc_pin_edge.sv */
/*
 * Synchroniser and edge detector for the external count pin.
 * Assumes pin changes are at least one clock apart.
 */
`timescale 1ns/100ps

module ptc_pin_edge (
	input wire logic          clk_in,
	input wire logic          rst_in,
	input wire logic          external_count_pin_in,
	input wire logic          pin_is_output_in,
	input wire logic          pin_drive_in,
	ptc_tick_if.edge_src      tick
);
	ptc_pkg::ptc_edge_state_t state_reg;
	ptc_pkg::ptc_edge_state_t state_next;
	logic                     level;

	// Driven value is on-chip, so it bypasses the synchroniser
	assign level = pin_is_output_in ? pin_drive_in : state_reg.sync_second;

	always_comb begin
		state_next             = state_reg;
		state_next.sync_first  = external_count_pin_in;
		state_next.sync_second = state_reg.sync_first;
		state_next.level_prev  = level;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Faster pin activity than one clock is lost
	assign tick.ext_rise = level & ~state_reg.level_prev;
	assign tick.ext_fall = ~level & state_reg.level_prev;
endmodule

/* File: hw/ptc_top.sv */
/*
 * Prescaled 8-bit up timer/counter with overflow flag, mask and interrupt.
 * Assumes a single-cycle register port, read data one cycle after the strobe.
 */
// Implementation choice: the strobed register port.
// Functional notes
// - 8-bit count clocked by clock, divided clock, pin, or stopped.
// - Divided clocks come from one free-running shared 10-bit prescaler.
// - Select: stop, clk, /8, /64, /256, /1024, pin fall, pin rise.
// - Divided selections are taken directly from the oscillator clock.
// - Stop selection holds the count unchanged.
// - External pin is sampled on rising CPU clock before edge detection.
// - Pin edges count even when the pin is driven as output.
// - Counter counts up only; software reads and writes it.
// - Written count loads, counting resumes from it next cycle.
// - Control bits 7..3 read zero; only select bits writable.
// - Overflow flag sits in the shared timer flag register.
// - Overflow interrupt gated by bit in shared timer mask register.
// - Acts as timer or event counter per clock select.
`timescale 1ns/100ps
`include "ptc_cfg.svh"

module ptc_top (
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	input  wire logic [`PTC_ADDR_W-1:0] addr_in,
	input  wire logic [`PTC_DATA_W-1:0] wdata_in,
	input  wire logic                   wr_in,
	input  wire logic                   rd_in,
	output logic      [`PTC_DATA_W-1:0] rdata_out,
	input  wire logic                   external_count_pin_in,
	input  wire logic                   port_b_line_zero_is_output_in,
	input  wire logic                   port_b_line_zero_drive_in,
	output logic                        irq_out,
	output logic      [`PTC_DATA_W-1:0] count_out
);
	ptc_tick_if                 tick ();
	ptc_pkg::ptc_core_state_t   state_reg;
	ptc_pkg::ptc_core_state_t   state_next;
	logic                       count_tick;
	logic                       count_wr;
	logic                       flag_rd;
	logic                       ovf_set;

	ptc_prescaler u_prescaler (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.tick   (tick.prescaler)
	);

	ptc_pin_edge u_pin_edge (
		.clk_in                (clk_in),
		.rst_in                (rst_in),
		.external_count_pin_in (external_count_pin_in),
		.pin_is_output_in      (port_b_line_zero_is_output_in),
		.pin_drive_in          (port_b_line_zero_drive_in),
		.tick                  (tick.edge_src)
	);

	function automatic logic sel_tick(
		input ptc_pkg::ptc_clk_sel_t sel,
		input logic [3:0]            div,
		input logic                  rise,
		input logic                  fall
	);
		logic t;
		t = 1'b0;
		case (sel)
			ptc_pkg::ptc_cs_stop:     t = 1'b0;
			ptc_pkg::ptc_cs_clk:      t = 1'b1;
			ptc_pkg::ptc_cs_div8:     t = div[0];
			ptc_pkg::ptc_cs_div64:    t = div[1];
			ptc_pkg::ptc_cs_div256:   t = div[2];
			ptc_pkg::ptc_cs_div1024:  t = div[3];
			ptc_pkg::ptc_cs_ext_fall: t = fall;
			ptc_pkg::ptc_cs_ext_rise: t = rise;
			default:                  t = 1'b0;
		endcase
		return t;
	endfunction

	assign count_tick = sel_tick(state_reg.clk_sel, tick.div_tick,
		tick.ext_rise, tick.ext_fall);
	assign count_wr   = wr_in && (addr_in == `PTC_ADDR_COUNT);
	assign flag_rd    = rd_in && (addr_in == `PTC_ADDR_FLAG);
	// Write outranks a tick in the same cycle, so no overflow from it
	assign ovf_set    = count_tick && !count_wr && (state_reg.count == `PTC_COUNT_MAX);

	always_comb begin
		state_next       = state_reg;
		state_next.rdata = '0;
		if (rd_in) begin
			if (addr_in == `PTC_ADDR_CONTROL) begin
				state_next.rdata[`PTC_CS_MSB:`PTC_CS_LSB] = state_reg.clk_sel;
			end else if (addr_in == `PTC_ADDR_COUNT) begin
				state_next.rdata = state_reg.count;
			end else if (addr_in == `PTC_ADDR_FLAG) begin
				state_next.rdata[`PTC_OVF_BIT] = state_reg.ovf_flag;
			end else if (addr_in == `PTC_ADDR_MASK) begin
				state_next.rdata[`PTC_OVF_BIT] = state_reg.ovf_mask;
			end else begin
				state_next.rdata = '0;
			end
		end
		if (wr_in) begin
			if (addr_in == `PTC_ADDR_CONTROL) begin
				state_next.clk_sel = ptc_pkg::ptc_clk_sel_t'(
					wdata_in[`PTC_CS_MSB:`PTC_CS_LSB]);
			end else if (addr_in == `PTC_ADDR_MASK) begin
				state_next.ovf_mask = wdata_in[`PTC_OVF_BIT];
			end
		end
		if (count_wr) begin
			state_next.count = wdata_in;
		end else if (count_tick) begin
			state_next.count = state_reg.count + `PTC_COUNT_STEP;
		end
		// Set beats the read clear so no overflow is lost
		if (flag_rd) begin
			state_next.ovf_flag = 1'b0;
		end
		if (ovf_set) begin
			state_next.ovf_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg.clk_sel  <= ptc_pkg::ptc_clk_sel_t'(`PTC_CONTROL_RST);
			state_reg.count    <= `PTC_COUNT_RST;
			state_reg.ovf_flag <= `PTC_FLAG_RST;
			state_reg.ovf_mask <= `PTC_MASK_RST;
			state_reg.rdata    <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_out = state_reg.rdata;
	assign count_out = state_reg.count;
	assign irq_out   = state_reg.ovf_flag & state_reg.ovf_mask;
endmodule

/* File: tb/ptc_pulse_src.sv */
/* Pulse source for the external count pin.
 Assumes run_in is held while pulses are wanted. */
`timescale 1ns/100ps
module ptc_pulse_src (
	input  wire logic clk_in,
	input  wire logic run_in,
	output logic      pin_out
);
	logic [1:0] ph_reg;
	// Three clocks a level, wider than the one-clock minimum
	always_ff @(posedge clk_in) begin
		if (!run_in) begin
			ph_reg  <= 2'h0;
			pin_out <= 1'b0;
		end else if (ph_reg == 2'h2) begin
			ph_reg  <= 2'h0;
			pin_out <= !pin_out;
		end else begin
			ph_reg <= ph_reg + 2'h1;
		end
	end
endmodule

/* File: tb/ptc_top_asserts.sv */
/* Port checker for ptc_top.
 Assumes binding to every ptc_top instance. */
`timescale 1ns/100ps
`include "ptc_cfg.svh"
module ptc_top_asserts (
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic       irq_out,
	input wire logic [7:0] count_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic wc;
	assign wc = wr_in && addr_in == `PTC_ADDR_COUNT;
	sequence s_rd_flag;
		rd_in && addr_in == `PTC_ADDR_FLAG && irq_out;
	endsequence
	property p_idle; !rd_in |=> rdata_out == 8'h00; endproperty
	property p_load; wc |=> count_out == $past(wdata_in); endproperty
	property p_up;
		!wc |=> count_out == $past(count_out) || count_out == $past(count_out) + 8'h01;
	endproperty
	property p_ctl; rd_in && addr_in == `PTC_ADDR_CONTROL |=> rdata_out[7:3] == 5'h00; endproperty
	property p_crd; rd_in && addr_in == `PTC_ADDR_COUNT |=> rdata_out == $past(count_out);
	endproperty
	property p_rise;
		$rose(irq_out) |-> $past(wr_in) || (count_out == 8'h00 && $past(count_out) == 8'hFF);
	endproperty
	property p_frd; s_rd_flag |=> rdata_out[0]; endproperty
	property p_clr; s_rd_flag |=> (!irq_out || count_out == 8'h00); endproperty
	property p_unm;
		rd_in && addr_in > `PTC_ADDR_MASK |=> rdata_out == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	a_load: assert property (p_load) else $error("count not loaded");
	a_up: assert property (p_up) else $error("count step wrong");
	a_ctl: assert property (p_ctl) else $error("control high bits");
	a_crd: assert property (p_crd) else $error("count read wrong");
	a_rise: assert property (p_rise) else $error("irq without cause");
	a_frd: assert property (p_frd) else $error("flag read wrong");
	a_clr: assert property (p_clr) else $error("flag not cleared");
	a_unm: assert property (p_unm) else $error("unmapped read");
endmodule
bind ptc_top ptc_top_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.irq_out(irq_out), .count_out(count_out));

/* File: tb/test_prescaled_8bit_timer_counter.sv */
/* Self-checking bench for ptc_top.
 Assumes the pulse source model and the bound checker. */
`timescale 1ns/100ps
`include "ptc_cfg.svh"
module test_prescaled_8bit_timer_counter;
	logic       clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, run = 0, pin, is_out = 0, drv = 0;
	logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, count_out, d;
	logic       irq_out;
	int         error_cnt = 0, n_checks = 0, cyc = 0, g;
	always #5 clk_in = !clk_in;
	ptc_pulse_src src (.clk_in(clk_in), .run_in(run), .pin_out(pin));
	ptc_top dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .external_count_pin_in(pin),
		.port_b_line_zero_is_output_in(is_out), .port_b_line_zero_drive_in(drv),
		.irq_out(irq_out), .count_out(count_out));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_in);
		{addr_in, wdata_in, wr_in} <= {a, v, 1'b1};
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		{addr_in, rd_in} <= {a, 1'b1};
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask
	task automatic t_reset;
		rd(`PTC_ADDR_CONTROL); chk(d, 8'h00);
		rd(`PTC_ADDR_COUNT); chk(d, 8'h00);
		rd(8'h40); chk(d, 8'h00);
		wr(`PTC_ADDR_CONTROL, 8'hF8); rd(`PTC_ADDR_CONTROL); chk(d, 8'h00);
	endtask
	task automatic t_ovf;
		wr(`PTC_ADDR_MASK, 8'h01);
		wr(`PTC_ADDR_CONTROL, 8'h01);
		wr(`PTC_ADDR_COUNT, 8'hFD); chk(count_out, 8'hFD);
		@(posedge clk_in); #1; chk(count_out, 8'hFE);
		repeat (3) @(posedge clk_in);
		#1; chk(irq_out, 1'b1);
		rd(`PTC_ADDR_FLAG); chk(d, 8'h01);
		rd(`PTC_ADDR_FLAG); chk(d, 8'h00);
		wr(`PTC_ADDR_MASK, 8'h00);
		repeat (260) @(posedge clk_in);
		#1; chk(irq_out, 1'b0);
		wr(`PTC_ADDR_MASK, 8'h01); chk(irq_out, 1'b1);
		rd(`PTC_ADDR_FLAG);
	endtask
	task automatic t_stop;
		wr(`PTC_ADDR_CONTROL, 8'h00);
		wr(`PTC_ADDR_COUNT, 8'h5A);
		repeat (30) @(posedge clk_in);
		#1; chk(count_out, 8'h5A);
	endtask
	task automatic t_div;
		int n[5] = '{1, 8, 64, 256, 1024};
		for (int i = 0; i < 5; i++) begin
			wr(`PTC_ADDR_CONTROL, 8'(i + 1));
			for (int k = 0; k < 2; k++) begin
				d = count_out;
				g = 0;
				do begin
					@(posedge clk_in); #1; g++;
				end while (count_out === d && g < 2100);
			end
			chk(g, n[i]);
		end
	endtask
	task automatic t_ext(input logic [7:0] m, input logic sw);
		wr(`PTC_ADDR_CONTROL, m);
		wr(`PTC_ADDR_COUNT, 8'h00);
		is_out <= sw;
		run <= !sw;
		for (int k = 0; k < 8; k++) begin
			repeat (3) @(posedge clk_in);
			drv <= sw && !drv;
		end
		// Stop on the eighth toggle, so four edges of each kind
		run <= 1'b0;
		repeat (11) @(posedge clk_in);
		rd(`PTC_ADDR_COUNT); chk(d, 8'h04);
		is_out <= 1'b0;
	endtask
	task report_and_stop;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	initial begin
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset; t_ovf; t_stop; t_div;
		t_ext(8'h07, 1'b0); t_ext(8'h06, 1'b0); t_ext(8'h07, 1'b1);
		report_and_stop;
	end
endmodule
